// *** verilog/skr_seal_key_request_checker.v ***
// Purpose : operand checks and seal key dependency record assembly
// Assumes : core holds operand and enclave inputs stable while busy
// Notes   : key derivation itself lives outside, on rec_o / key_i
`timescale 1ns/1ps
`include "skr_defines.vh"

module skr_seal_key_request_checker (
    // clock and reset
    input  wire                   sys_clk_i,
    input  wire                   resetn_i,
    // register port
    input  wire [`SKR_RADDR_W-1:0] reg_addr_i,
    input  wire [31:0]            reg_wdata_i,
    input  wire                   reg_wr_i,
    input  wire                   reg_rd_i,
    output wire [31:0]            reg_rdata_o,
    // instruction dispatch
    input  wire                   start_i,
    input  wire [63:0]            req_ptr_i,
    input  wire [63:0]            out_ptr_i,
    input  wire [63:0]            elr_base_i,
    input  wire [63:0]            elr_end_i,
    // page metadata, index 0 request page, index 1 output page
    input  wire [1:0]             pg_in_cache_i,
    input  wire [1:0]             pg_valid_i,
    input  wire [1:0]             pg_blocked_i,
    input  wire [1:0]             pg_regular_i,
    input  wire [1:0]             pg_owned_i,
    input  wire [1:0]             pg_pending_i,
    input  wire [1:0]             pg_modified_i,
    input  wire [1:0]             pg_read_i,
    input  wire [1:0]             pg_write_i,
    input  wire [127:0]           pg_addr_i,
    // key request structure
    input  wire [15:0]            req_key_type_i,
    input  wire [15:0]            req_policy_i,
    input  wire [`SKR_RSVD_W-1:0] req_rsvd_i,
    input  wire [255:0]           req_salt_i,
    input  wire [127:0]           req_cpu_ver_i,
    input  wire [15:0]            req_sw_ver_i,
    input  wire [15:0]            req_cfg_ver_i,
    input  wire [127:0]           req_attr_mask_i,
    input  wire [31:0]            req_misc_mask_i,
    input  wire [7:0]             req_ss_mask_i,
    // enclave control structure
    input  wire [127:0]           enc_attr_i,
    input  wire [31:0]            enc_misc_i,
    input  wire [7:0]             enc_ss_attr_i,
    input  wire [15:0]            enc_sw_ver_i,
    input  wire [15:0]            enc_cfg_ver_i,
    input  wire [255:0]           enc_meas_i,
    input  wire [255:0]           enc_signer_i,
    input  wire [127:0]           enc_family_i,
    input  wire [127:0]           enc_extprod_i,
    input  wire [15:0]            enc_prod_i,
    input  wire [511:0]           enc_cfgid_i,
    input  wire [`SKR_PAD_W-1:0]  enc_pad_i,
    // platform values
    input  wire [127:0]           owner_epoch_i,
    input  wire [127:0]           seal_fuse_i,
    input  wire [127:0]           cpu_ver_i,
    // key derivation engine
    output wire [`SKR_REC_W-1:0]  rec_o,
    output wire                   rec_vld_o,
    input  wire [127:0]           key_i,
    input  wire                   key_vld_i,
    // results
    output wire                   done_o,
    output wire                   gp_fault_o,
    output wire                   page_fault_o,
    output wire [63:0]            fault_addr_o,
    output wire                   zf_o,
    output wire [31:0]            status_o,
    output wire [4:0]             arith_flags_o,
    output wire                   key_wr_o,
    output wire [63:0]            key_addr_o,
    output wire [127:0]           key_data_o
);

    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_WAIT = 2'b10;

    reg [1:0]             state_ff;
    reg [1:0]             nxt_state;
    reg                   sscap_ff;
    reg [31:0]            rdata_ff;
    reg [`SKR_REC_W-1:0]  rec_ff;
    reg                   rec_vld_ff;
    reg                   done_ff;
    reg                   gp_ff;
    reg                   pf_ff;
    reg [63:0]            faddr_ff;
    reg                   zf_ff;
    reg [31:0]            status_ff;
    reg                   key_wr_ff;
    reg [127:0]           key_ff;
    reg [63:0]            kaddr_ff;
    reg [4:0]             arith_ff;

    // ---------------------------------------------------------------
    // page metadata checks, one instance per operand
    // ---------------------------------------------------------------
    wire [127:0] ptrs = {out_ptr_i, req_ptr_i};
    wire [1:0]   pg_present;
    wire [1:0]   pg_attr_ok;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_page
            // presence first: cached, valid and not blocked
            assign pg_present[g] = pg_in_cache_i[g] & pg_valid_i[g] &
                                   ~pg_blocked_i[g];
            // request page needs read, output page needs write
            assign pg_attr_ok[g] = pg_regular_i[g] & pg_owned_i[g] &
                ~pg_pending_i[g] & ~pg_modified_i[g] &
                ((g == 0) ? pg_read_i[g] : pg_write_i[g]) &
                (pg_addr_i[g*64 +: 64] ==
                 (ptrs[g*64 +: 64] & ~`SKR_PAGE_OFS_MASK));
        end
    endgenerate

    // ---------------------------------------------------------------
    // fault conditions
    // ---------------------------------------------------------------
    wire req_gp  = |req_ptr_i[`SKR_REQ_ALIGN_MSB:0];
    wire req_pf  = ~pg_present[0] | ~pg_attr_ok[0];
    wire out_gp  = (|out_ptr_i[`SKR_OUT_ALIGN_MSB:0]) |
                   (out_ptr_i < elr_base_i) |
                   (out_ptr_i >= elr_end_i);
    wire out_pf  = ~pg_present[1] | ~pg_attr_ok[1];
    wire rsvd_gp = (|req_rsvd_i) |
                   (|(req_policy_i & `SKR_POL_RSVD_MASK));
    // without key separation the newer policy bits must stay clear
    wire sep_gp  = ~enc_attr_i[`SKR_ATTR_SEP_BIT] &
                   ((|(req_policy_i & `SKR_POL_SEP_MASK)) |
                    (req_cfg_ver_i != 16'h0000));
    // an earlier operand check masks every later one
    wire any_gp  = req_gp | (~req_pf & (out_gp |
                   (~out_pf & (rsvd_gp | sep_gp))));
    wire any_pf  = ~req_gp & (req_pf | (~out_gp & out_pf));
    // page fault reports the operand that failed first
    wire [63:0] pf_addr = req_pf ? req_ptr_i : out_ptr_i;

    // ---------------------------------------------------------------
    // status checks, only reached when no fault stands
    // ---------------------------------------------------------------
    wire is_seal  = (req_key_type_i == `SKR_KEY_SEAL);
    wire bad_cpu  = req_cpu_ver_i > cpu_ver_i;
    wire bad_sw   = req_sw_ver_i > enc_sw_ver_i;
    wire bad_cfg  = req_cfg_ver_i > enc_cfg_ver_i;
    reg  [31:0] chk_status;
    reg         chk_err;
    // key type first, then versions in a fixed order
    always @* begin
        chk_err    = 1'b1;
        chk_status = `SKR_ST_OK;
        if (!is_seal) begin
            chk_status = `SKR_ST_BAD_KEY;
        end else if (bad_cpu) begin
            chk_status = `SKR_ST_BAD_CPU;
        end else if (bad_sw || bad_cfg) begin
            chk_status = `SKR_ST_BAD_SW;
        end else begin
            chk_err = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // derived inputs and record fields
    // ---------------------------------------------------------------
    wire [127:0] seal_attr = (req_attr_mask_i | `SKR_SEAL_REQ_MASK) &
                             enc_attr_i;
    wire [31:0]  misc_sel  = req_misc_mask_i & enc_misc_i;
    // shadow stack fields stay zero unless the capability is present
    wire [7:0]   ss_attr   = sscap_ff ?
                             (req_ss_mask_i & enc_ss_attr_i) : 8'h00;
    wire [7:0]   ss_mask   = sscap_ff ? req_ss_mask_i : 8'h00;
    wire [255:0] f_meas    = req_policy_i[`SKR_POL_MEAS] ?
                             enc_meas_i : 256'h0;
    wire [255:0] f_signer  = req_policy_i[`SKR_POL_SIGNER] ?
                             enc_signer_i : 256'h0;
    wire [127:0] f_family  = req_policy_i[`SKR_POL_FAMILY] ?
                             enc_family_i : 128'h0;
    wire [127:0] f_extprod = req_policy_i[`SKR_POL_EXTPROD] ?
                             enc_extprod_i : 128'h0;
    wire [15:0]  f_prod    = req_policy_i[`SKR_POL_NOPROD] ?
                             16'h0000 : enc_prod_i;
    wire [511:0] f_cfgid   = req_policy_i[`SKR_POL_CFGID] ?
                             enc_cfgid_i : 512'h0;
    wire [15:0]  f_cfgver  = req_policy_i[`SKR_POL_CFGID] ?
                             req_cfg_ver_i : 16'h0000;

    // full seal record, most significant field first
    wire [`SKR_REC_W-1:0] seal_rec = {
        `SKR_KEY_SEAL,
        f_family,
        f_extprod,
        f_prod,
        req_sw_ver_i,
        owner_epoch_i,
        seal_attr,
        req_attr_mask_i,
        f_meas,
        f_signer,
        req_salt_i,
        seal_fuse_i,
        req_cpu_ver_i,
        enc_pad_i,
        misc_sel,
        ~req_misc_mask_i,
        req_policy_i,
        f_cfgid,
        f_cfgver,
        ss_attr,
        ss_mask
    };

    // ---------------------------------------------------------------
    // sequencing: check on start, then wait for the derived key
    // ---------------------------------------------------------------
    // the block raises no conflict indication at all: both operand
    // accesses proceed beside page-management operations
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start_i && !any_gp && !any_pf && !chk_err) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (key_vld_i) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // result registers; faults win over any status code
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff   <= ST_IDLE;
            rec_ff     <= {`SKR_REC_W{1'b0}};
            rec_vld_ff <= 1'b0;
            done_ff    <= 1'b0;
            gp_ff      <= 1'b0;
            pf_ff      <= 1'b0;
            faddr_ff   <= 64'h0000_0000_0000_0000;
            zf_ff      <= 1'b0;
            status_ff  <= `SKR_ST_OK;
            key_wr_ff  <= 1'b0;
            key_ff     <= 128'h0;
            kaddr_ff   <= 64'h0000_0000_0000_0000;
            arith_ff   <= 5'h00;
        end else begin
            state_ff   <= nxt_state;
            // no exit ever sets an arithmetic flag
            arith_ff   <= 5'h00;
            done_ff    <= 1'b0;
            key_wr_ff  <= 1'b0;
            rec_vld_ff <= 1'b0;
            if (state_ff == ST_IDLE && start_i) begin
                gp_ff    <= any_gp;
                pf_ff    <= any_pf;
                faddr_ff <= any_pf ? pf_addr : 64'h0000_0000_0000_0000;
                // record cleared, filled only on the seal path
                rec_ff   <= {`SKR_REC_W{1'b0}};
                if (any_gp || any_pf) begin
                    done_ff <= 1'b1;
                end else if (chk_err) begin
                    done_ff   <= 1'b1;
                    zf_ff     <= 1'b1;
                    status_ff <= chk_status;
                end else begin
                    rec_ff     <= seal_rec;
                    rec_vld_ff <= 1'b1;
                    kaddr_ff   <= out_ptr_i;
                end
            end else if (state_ff == ST_WAIT && key_vld_i) begin
                key_ff    <= key_i;
                key_wr_ff <= 1'b1;
                done_ff   <= 1'b1;
                zf_ff     <= 1'b0;
                status_ff <= `SKR_ST_OK;
            end
        end
    end

    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    // control write: shadow stack capability steers
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sscap_ff <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == `SKR_REG_CTRL) begin
            sscap_ff <= reg_wdata_i[`SKR_CTRL_SSCAP];
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `SKR_REG_CTRL: begin
                    rdata_ff <= {31'h0, sscap_ff};
                end
                `SKR_REG_STAT: begin
                    rdata_ff <= {20'h0_0000, state_ff == ST_WAIT,
                                 pf_ff, gp_ff, zf_ff, status_ff[7:0]};
                end
                default: begin
                    rdata_ff <= 32'h0000_0000;
                end
            endcase
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all from flops
    // ---------------------------------------------------------------
    assign reg_rdata_o   = rdata_ff;
    assign rec_o         = rec_ff;
    assign rec_vld_o     = rec_vld_ff;
    assign done_o        = done_ff;
    assign gp_fault_o    = gp_ff;
    assign page_fault_o  = pf_ff;
    assign fault_addr_o  = faddr_ff;
    assign zf_o          = zf_ff;
    assign status_o      = status_ff;
    // carry, parity, adjust, overflow, sign held clear in a flop
    assign arith_flags_o = arith_ff;
    assign key_wr_o      = key_wr_ff;
    assign key_addr_o    = kaddr_ff;
    assign key_data_o    = key_ff;

endmodule

// *** verilog/skr_defines.vh ***
// Purpose : constants for the sealing key request checker
// Assumes : included by bare name from the design file
// Notes   : widths follow the request and control structure fields
`ifndef SKR_DEFINES_VH
`define SKR_DEFINES_VH

// ---------------------------------------------------------------
// register port
// ---------------------------------------------------------------
`define SKR_RADDR_W        4
`define SKR_REG_CTRL       4'h0
`define SKR_REG_STAT       4'h4
`define SKR_CTRL_SSCAP     0
`define SKR_STAT_ZF        8
`define SKR_STAT_GP        9
`define SKR_STAT_PF        10
`define SKR_STAT_BUSY      11

// ---------------------------------------------------------------
// alignment and page address
// ---------------------------------------------------------------
`define SKR_REQ_ALIGN_MSB  8
`define SKR_OUT_ALIGN_MSB  3
`define SKR_PAGE_OFS_MASK  64'h0000_0000_0000_0fff

// ---------------------------------------------------------------
// derivation policy field
// ---------------------------------------------------------------
`define SKR_POL_MEAS       0
`define SKR_POL_SIGNER     1
`define SKR_POL_NOPROD     2
`define SKR_POL_CFGID      3
`define SKR_POL_FAMILY     4
`define SKR_POL_EXTPROD    5
`define SKR_POL_RSVD_MASK  16'hffc0
`define SKR_POL_SEP_MASK   16'h003c
`define SKR_ATTR_SEP_BIT   7

// ---------------------------------------------------------------
// key types, status codes, fixed masks
// ---------------------------------------------------------------
`define SKR_KEY_SEAL       16'h0004
`define SKR_ST_OK          32'h0000_0000
`define SKR_ST_BAD_CPU     32'h0000_0020
`define SKR_ST_BAD_SW      32'h0000_0040
`define SKR_ST_BAD_KEY     32'h0000_0051
`define SKR_SEAL_REQ_MASK  128'h0000_0000_0000_0000_0000_0000_0000_0003

// ---------------------------------------------------------------
// field widths
// ---------------------------------------------------------------
`define SKR_RSVD_W         64
`define SKR_PAD_W          2816
`define SKR_REC_W          5152

`endif

// *** test/skr_props.sv ***
// Purpose : port assertions for the seal key request checker
// Assumes : one clock domain, asynchronous active-low reset
// Notes   : wait_ff follows the key wait, from record pulse to done
`timescale 1ns/1ps
module skr_props (
    // clock and reset
    input wire         sys_clk_i,
    input wire         resetn_i,
    // request side
    input wire         start_i,
    input wire [63:0]  req_ptr_i,
    input wire [63:0]  out_ptr_i,
    input wire         key_vld_i,
    input wire [127:0] key_i,
    // results
    input wire         rec_vld_o,
    input wire         done_o,
    input wire         gp_fault_o,
    input wire         page_fault_o,
    input wire [63:0]  fault_addr_o,
    input wire         zf_o,
    input wire [31:0]  status_o,
    input wire [4:0]   arith_flags_o,
    input wire         key_wr_o,
    input wire [63:0]  key_addr_o,
    input wire [127:0] key_data_o
);
    // a start during the key wait is ignored, so it must not arm checks
    logic wait_ff;
    wire  busy = wait_ff | rec_vld_o;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            wait_ff <= 1'b0;
        else if (done_o)
            wait_ff <= 1'b0;
        else if (rec_vld_o)
            wait_ff <= 1'b1;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    chk_align_fault:
        assert property (start_i && !busy && req_ptr_i[8:0] != 9'h000
            |=> done_o && gp_fault_o) else $error("misaligned request ok");
    chk_one_answer:
        assert property (start_i && !busy |=> rec_vld_o != done_o)
            else $error("start gave no single answer");
    chk_fault_nowr:
        assert property (done_o && (gp_fault_o || page_fault_o) |-> !key_wr_o)
            else $error("key written on fault");
    chk_key_echo:
        assert property (key_vld_i && wait_ff |=> key_wr_o && done_o
            && key_data_o == $past(key_i) && key_addr_o == out_ptr_i)
            else $error("key not written whole");
    chk_ok_status:
        assert property (key_wr_o |-> !zf_o && status_o == 32'h0000_0000)
            else $error("success status wrong");
    chk_flags_zero:
        assert property (done_o |-> arith_flags_o == 5'h00)
            else $error("arith flags not cleared");
    chk_pf_addr:
        assert property (done_o && page_fault_o
            |-> fault_addr_o == req_ptr_i || fault_addr_o == out_ptr_i)
            else $error("page fault address wrong");
    chk_err_zf:
        assert property (done_o && !gp_fault_o && !page_fault_o && !key_wr_o
            |-> zf_o && status_o != 32'h0000_0000) else $error("error lost");
endmodule
bind skr_seal_key_request_checker skr_props u_props (
    .sys_clk_i, .resetn_i, .start_i, .req_ptr_i, .out_ptr_i, .key_vld_i,
    .key_i, .rec_vld_o, .done_o, .gp_fault_o, .page_fault_o, .fault_addr_o,
    .zf_o, .status_o, .arith_flags_o, .key_wr_o, .key_addr_o, .key_data_o
);

// *** test/tb_top.sv ***
// Purpose : self-checking bench for the seal key request checker
// Assumes : one-cycle read data on the register port, 10 MHz clock
// Notes   : set_good builds a passing request, scenarios spoil it
`timescale 1ns/1ps
`include "skr_defines.vh"
module tb_top;
    logic          sys_clk_i, resetn_i, reg_wr_i, reg_rd_i, start_i;
    logic          key_vld_i, rec_vld_o, done_o, gp_fault_o, page_fault_o;
    logic          zf_o, key_wr_o;
    logic [1:0]    pg_in_cache_i, pg_valid_i, pg_blocked_i, pg_regular_i;
    logic [1:0]    pg_owned_i, pg_pending_i, pg_modified_i, pg_read_i;
    logic [1:0]    pg_write_i;
    logic [3:0]    reg_addr_i;
    logic [4:0]    arith_flags_o;
    logic [7:0]    req_ss_mask_i, enc_ss_attr_i;
    logic [15:0]   req_key_type_i, req_policy_i, req_sw_ver_i, req_cfg_ver_i;
    logic [15:0]   enc_sw_ver_i, enc_cfg_ver_i, enc_prod_i;
    logic [31:0]   reg_wdata_i, reg_rdata_o, req_misc_mask_i, enc_misc_i;
    logic [31:0]   status_o;
    logic [63:0]   req_ptr_i, out_ptr_i, elr_base_i, elr_end_i, req_rsvd_i;
    logic [63:0]   fault_addr_o, key_addr_o;
    logic [127:0]  pg_addr_i, req_cpu_ver_i, req_attr_mask_i, enc_attr_i;
    logic [127:0]  enc_family_i, enc_extprod_i, owner_epoch_i, seal_fuse_i;
    logic [127:0]  cpu_ver_i, key_i, key_data_o;
    logic [255:0]  req_salt_i, enc_meas_i, enc_signer_i;
    logic [511:0]  enc_cfgid_i;
    logic [2815:0] enc_pad_i;
    logic [5151:0] rec_o;
    int            num_errors, n_checks;

    skr_seal_key_request_checker dut (
        .sys_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .start_i, .req_ptr_i, .out_ptr_i,
        .elr_base_i, .elr_end_i, .pg_in_cache_i, .pg_valid_i, .pg_blocked_i,
        .pg_regular_i, .pg_owned_i, .pg_pending_i, .pg_modified_i,
        .pg_read_i, .pg_write_i, .pg_addr_i, .req_key_type_i, .req_policy_i,
        .req_rsvd_i, .req_salt_i, .req_cpu_ver_i, .req_sw_ver_i,
        .req_cfg_ver_i, .req_attr_mask_i, .req_misc_mask_i, .req_ss_mask_i,
        .enc_attr_i, .enc_misc_i, .enc_ss_attr_i, .enc_sw_ver_i,
        .enc_cfg_ver_i, .enc_meas_i, .enc_signer_i, .enc_family_i,
        .enc_extprod_i, .enc_prod_i, .enc_cfgid_i, .enc_pad_i,
        .owner_epoch_i, .seal_fuse_i, .cpu_ver_i, .rec_o, .rec_vld_o,
        .key_i, .key_vld_i, .done_o, .gp_fault_o, .page_fault_o,
        .fault_addr_o, .zf_o, .status_o, .arith_flags_o, .key_wr_o,
        .key_addr_o, .key_data_o
    );

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [5151:0] got, input logic [5151:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t result mismatch", $time);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask
    // distinct patterns per field so a swapped field shows up
    task automatic set_good(input logic [15:0] pol);
        {req_ptr_i, out_ptr_i} <= {64'h0001_0200, 64'h0002_0010};
        {elr_base_i, elr_end_i} <= {64'h0001_0000, 64'h0010_0000};
        pg_addr_i <= {64'h0002_0000, 64'h0001_0000};
        {pg_in_cache_i, pg_valid_i, pg_regular_i} <= 6'h3f;
        {pg_owned_i, pg_read_i, pg_write_i} <= 6'h3f;
        {pg_blocked_i, pg_pending_i, pg_modified_i} <= 6'h00;
        {req_key_type_i, req_policy_i} <= {`SKR_KEY_SEAL, pol};
        req_rsvd_i <= 64'h0;
        {req_cpu_ver_i, cpu_ver_i} <= {128'h10, 128'h20};
        {req_sw_ver_i, enc_sw_ver_i} <= 32'h0003_0005;
        {req_cfg_ver_i, enc_cfg_ver_i} <= 32'h0001_0002;
        {req_attr_mask_i, enc_attr_i} <= {128'hf0, 128'h1a3};
        {req_misc_mask_i, enc_misc_i} <= 64'h0000_ff0f_1234_5678;
        {req_ss_mask_i, enc_ss_attr_i, enc_prod_i} <= 32'h3ca5_beef;
        {req_salt_i, enc_meas_i} <= {{8{32'h5a5a_0001}}, {8{32'h1234_abcd}}};
        enc_signer_i <= {8{32'hc3c3_0f0f}};
        enc_cfgid_i <= {16{32'h7777_0123}};
        enc_family_i <= {4{32'h0f1e_2d3c}};
        enc_extprod_i <= {4{32'h9988_7766}};
        owner_epoch_i <= {4{32'h0e0e_0001}};
        seal_fuse_i <= {4{32'hf00d_0002}};
        {enc_pad_i, key_i} <= {{88{32'hffff_0100}}, {4{32'hcafe_1234}}};
    endtask
    function automatic logic [5151:0] exp_rec(input logic ss);
        logic [15:0] p;
        p = req_policy_i;
        return {req_key_type_i, p[4] ? enc_family_i : 128'h0,
            p[5] ? enc_extprod_i : 128'h0, p[2] ? 16'h0 : enc_prod_i,
            req_sw_ver_i, owner_epoch_i,
            (req_attr_mask_i | 128'h3) & enc_attr_i,
            req_attr_mask_i, p[0] ? enc_meas_i : 256'h0,
            p[1] ? enc_signer_i : 256'h0, req_salt_i, seal_fuse_i,
            req_cpu_ver_i,
            enc_pad_i, req_misc_mask_i & enc_misc_i, ~req_misc_mask_i, p,
            p[3] ? enc_cfgid_i : 512'h0, p[3] ? req_cfg_ver_i : 16'h0,
            ss ? req_ss_mask_i & enc_ss_attr_i : 8'h0,
            ss ? req_ss_mask_i : 8'h0};
    endfunction
    task automatic fire;
        start_i <= 1'b1;
        @(posedge sys_clk_i);
        start_i <= 1'b0;
        #1;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic run_seal(input logic [15:0] pol, input logic ss);
        reg_write(`SKR_REG_CTRL, {31'h0, ss});
        reg_check(`SKR_REG_CTRL, {31'h0, ss});
        @(posedge sys_clk_i);
        set_good(pol);
        fire();
        chk({rec_vld_o, done_o}, 2'b10);
        chk(rec_o, exp_rec(ss));
        reg_check(`SKR_REG_STAT, 32'h0000_0800);
        @(posedge sys_clk_i);
        key_vld_i <= 1'b1;
        @(posedge sys_clk_i);
        key_vld_i <= 1'b0;
        #1 chk({key_wr_o, done_o, zf_o, arith_flags_o, status_o, key_addr_o,
            key_data_o}, {8'hc0, 32'h0, out_ptr_i, key_i});
        reg_check(`SKR_REG_STAT, 32'h0);
    endtask
    task automatic t_seal;
        run_seal(16'h003f, 1'b1);
        run_seal(16'h0000, 1'b0);
        run_seal(16'h002b, 1'b1);
    endtask
    task automatic t_faults;
        logic gp;
        for (int i = 0; i < 11; i++) begin
            @(posedge sys_clk_i);
            set_good(16'h0000);
            @(posedge sys_clk_i);
            case (i)
                0: req_ptr_i <= 64'h0001_0240;
                1: pg_valid_i <= 2'b10;
                2: pg_addr_i[63:0] <= 64'h0003_0000;
                3: pg_read_i <= 2'b10;
                4: out_ptr_i <= 64'h0002_0018;
                5: out_ptr_i <= 64'h0020_0010;
                6: pg_write_i <= 2'b01;
                7: {req_rsvd_i, req_cpu_ver_i} <= {64'h1, 128'hff};
                8: req_policy_i <= 16'h0040;
                9: {enc_attr_i, req_policy_i} <= {128'h3, 16'h0004};
                default: enc_attr_i <= 128'h3;
            endcase
            fire();
            gp = (i == 0) || (i == 4) || (i == 5) || (i >= 7);
            chk({done_o, gp_fault_o, page_fault_o, key_wr_o, rec_vld_o},
                {1'b1, gp, ~gp, 2'b00});
            chk({zf_o, status_o}, 33'h0);
            if (!gp)
                chk(fault_addr_o, i < 4 ? req_ptr_i : out_ptr_i);
        end
    endtask
    task automatic t_status;
        logic [31:0] st;
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk_i);
            set_good(16'h0000);
            @(posedge sys_clk_i);
            case (i)
                0: req_cpu_ver_i <= 128'h21;
                1: req_sw_ver_i <= 16'h0006;
                2: req_cfg_ver_i <= 16'h0003;
                3: req_key_type_i <= 16'h0001;
                default: req_key_type_i <= 16'h0005;
            endcase
            fire();
            st = (i == 0) ? `SKR_ST_BAD_CPU :
                 (i < 3) ? `SKR_ST_BAD_SW : `SKR_ST_BAD_KEY;
            chk({done_o, gp_fault_o, page_fault_o, key_wr_o, rec_vld_o, zf_o,
                status_o}, {6'b100001, st});
            reg_check(`SKR_REG_STAT, {23'h0, 1'b1, st[7:0]});
        end
        reg_write(4'h8, 32'hffff_ffff);
        reg_check(4'h8, 32'h0);
    endtask

    // clock, then reset for ten cycles and the scenarios
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        {resetn_i, reg_wr_i, reg_rd_i, start_i, key_vld_i} = 5'h00;
        {reg_addr_i, reg_wdata_i} = 36'h0;
        num_errors = 0;
        n_checks = 0;
        set_good(16'h0000);
        repeat (10) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        t_seal();
        t_faults();
        t_status();
        give_verdict();
    end
    // the scenarios need about a hundred and ten cycles; a thousand means a hang
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
endmodule
